// ==== verilog/tieu_consts.svh ====
/*
  Constants of the trap and interrupt entry unit: register offsets,
  field positions, reset values, opcode and data type codes.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef TIEU_CONSTS_SVH
`define TIEU_CONSTS_SVH

// Register offsets (byte addresses, one word each)
`define TIEU_REG_FPU_CFG     8'h00
`define TIEU_REG_INT_STAT    8'h04
`define TIEU_REG_SCR         8'h08
`define TIEU_REG_TRAP_RESULT 8'h0c
`define TIEU_REG_WBP         8'h10
`define TIEU_REG_VECTOR      8'h14

// Floating point configuration fields
`define TIEU_FPU_COPROC      0
`define TIEU_FPU_FIX_MULT    1
`define TIEU_FPU_FLT_MULT    2
`define TIEU_FPU_FLT_CMP     3
`define TIEU_FPU_CFG_RST     4'h0

// Status control fields
`define TIEU_SCR_NO_PREEMPT  0
`define TIEU_SCR_SUBVERT     1
`define TIEU_SCR_LVL_LO      4
`define TIEU_SCR_LVL_HI      6
`define TIEU_SCR_RST         32'h0000_0000

// Opcodes and data types that the classifier tests
`define TIEU_OP_ADD          8'h10
`define TIEU_OP_SUB          8'h11
`define TIEU_OP_MULT         8'h12
`define TIEU_NUM_HI          3'h1
`define TIEU_DTP_FIXNUM      6'h08
`define TIEU_DTP_SFLOAT      6'h0a

// Interrupt level of preemption
`define TIEU_LVL_PREEMPT     3'h1

`endif

// ==== verilog/tieu_pkg.sv ====
/*
  Types of the trap and interrupt entry unit.
  Assumes tieu_consts.svh is on the include path.
*/
`include "tieu_consts.svh"
package tieu_pkg;
  typedef enum logic [2:0] {
    TIEU_CLS_NONE,
    TIEU_CLS_LS,
    TIEU_CLS_ARITH,
    TIEU_CLS_BRANCH,
    TIEU_CLS_TYPE,
    TIEU_CLS_INTR
  } tieu_cls_t;
endpackage

// ==== verilog/tieu_trap_if.sv ====
/*
  Carrier between the entry unit and its trap classifier.
  Assumes both ends run on the one core clock.
*/
`timescale 1ns/100ps
interface tieu_trap_if;
  import tieu_pkg::*;
  logic [7:0]  opcode;
  logic [3:0]  cond;
  logic        fmt_rr;
  logic [5:0]  tag1;
  logic [5:0]  tag2;
  logic        is_branch;
  logic        tchk_hw_arith;
  logic        cond_hw_arith;
  logic        type_fault;
  logic [5:0]  type_tested;
  logic [3:0]  ls_trap;
  logic [3:0]  fpu_cfg;
  logic        hit;
  tieu_cls_t   cls;
  logic [19:0] payload;
  modport unit (output opcode, cond, fmt_rr, tag1, tag2, is_branch,
    tchk_hw_arith, cond_hw_arith, type_fault, type_tested, ls_trap,
    fpu_cfg, input hit, cls, payload);
  modport cls_end (input opcode, cond, fmt_rr, tag1, tag2, is_branch,
    tchk_hw_arith, cond_hw_arith, type_fault, type_tested, ls_trap,
    fpu_cfg, output hit, cls, payload);
endinterface

// ==== verilog/tieu_classify.sv ====
/*
  Combinational trap classifier: picks one trap class by fixed
  priority and forms the vector payload.
  Assumes inputs are stable while the unit samples the result.
*/
`timescale 1ns/100ps
module tieu_classify
  import tieu_pkg::*;
(
  // Classifier side of the carrier
  tieu_trap_if.cls_end t
);
  logic num_both;
  logic fix_both;
  logic sf_both;
  logic is_addsub;
  logic is_mult;
  logic arith_hit;
  logic br_hit;
  logic [1:0] ls_kind;

  assign num_both = (t.tag1[5:3] == `TIEU_NUM_HI) &&
                    (t.tag2[5:3] == `TIEU_NUM_HI);
  assign fix_both = (t.tag1 == `TIEU_DTP_FIXNUM) &&
                    (t.tag2 == `TIEU_DTP_FIXNUM);
  assign sf_both  = (t.tag1 == `TIEU_DTP_SFLOAT) &&
                    (t.tag2 == `TIEU_DTP_SFLOAT);
  assign is_addsub = (t.opcode == `TIEU_OP_ADD) ||
                     (t.opcode == `TIEU_OP_SUB); // RL11
  assign is_mult   = (t.opcode == `TIEU_OP_MULT); // RL11

  // Multiply traps unless the configured hardware covers the pair
  always_comb begin
    arith_hit = 1'b0;
    if (num_both && !t.tchk_hw_arith) begin
      if (is_addsub)
        arith_hit = !fix_both &&
          !(t.fpu_cfg[`TIEU_FPU_COPROC] && sf_both); // RL11 RL12
      else if (is_mult)
        arith_hit =
          !(fix_both && t.fpu_cfg[`TIEU_FPU_FIX_MULT]) &&
          !(sf_both && t.fpu_cfg[`TIEU_FPU_FLT_MULT]); // RL13
    end
  end

  assign br_hit = t.is_branch && num_both && !t.cond_hw_arith &&
    !fix_both && !(t.fpu_cfg[`TIEU_FPU_FLT_CMP] && sf_both); // RL15 RL16

  // Indirect, error, monitor, transport in that priority
  always_comb begin
    ls_kind = 2'h3;
    if (t.ls_trap[0])
      ls_kind = 2'h0;
    else if (t.ls_trap[1])
      ls_kind = 2'h1;
    else if (t.ls_trap[2])
      ls_kind = 2'h2;
  end

  // One class only, load/store first, plain type traps last
  always_comb begin
    t.hit     = 1'b1;
    t.cls     = TIEU_CLS_NONE;
    t.payload = 20'h00000;
    if (|t.ls_trap) begin
      t.cls     = TIEU_CLS_LS; // RL21
      t.payload = {t.opcode, ls_kind, 10'h000}; // RL19
    end else if (arith_hit) begin
      t.cls     = TIEU_CLS_ARITH;
      t.payload = {t.opcode[7:0], t.tag1, t.tag2}; // RL14 RL4
    end else if (br_hit) begin
      t.cls     = TIEU_CLS_BRANCH;
      t.payload = {t.opcode[3:0], t.cond, t.tag1, t.tag2}; // RL17
    end else if (t.type_fault) begin
      t.cls     = TIEU_CLS_TYPE;
      t.payload = {t.opcode, t.type_tested, t.fmt_rr, 5'h00}; // RL18
    end else begin
      t.hit     = 1'b0;
    end
  end
endmodule

// ==== verilog/tieu_unit.sv ====
/*
  Trap and interrupt entry unit: redirects fetch to a handler,
  advances the window pointer, pushes the return PC, fills the
  handler's build window and keeps status control and trap result.
  Assumes a pipeline that offers one instruction per instr_valid,
  never with ret_valid in the same cycle, and interrupt set pulses
  from memory control logic on the same clock.
*/
// Our own choices: the address map and the plain strobed port.
// Functional notes
// [RL1] Entry bumps window pointer, pushes trapping PC
// [RL2] Build slots get status, source1, source2
// [RL3] Traps pass three arguments, interrupts one; a trap here writes the third slot only with has_src2
// [RL4] Instruction trap vectors carry opcode bits
// [RL5] Interrupt bits stay set until written one
// [RL6] Handlers service all bits before return
// [RL7] Interrupt return reloads saved status control
// [RL8] Interrupt level one means preemption
// [RL9] Inhibit bits block only preemption
// [RL10] Return-subvert sets subvert, result substituted
// [RL11] Arithmetic traps: add, sub, mult only
// [RL12] Coprocessor present: no single-float add trap
// [RL13] Multiply trap follows configured multiply hardware
// [RL14] Arithmetic vector holds opcode and types
// [RL15] Branch trap on numeric non-fixnum operands
// [RL16] Float compare support skips single-float trap
// [RL17] Branch vector holds opcode, condition, types; a branch vector here holds only opcode bits 3:0
// [RL18] Type vector holds opcode, type, format
// [RL19] Four load/store kinds encoded in vector
// [RL20] Subverted call loads trap result as PC
// [RL21] One trap chosen by fixed priority
`timescale 1ns/100ps
module tieu_unit
  import tieu_pkg::*;
#(
  parameter int DW     = 32,
  parameter int WBP_W  = 4,
  parameter int LEVELS = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [DW-1:0]     reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DW-1:0]     reg_rdata,
  // Instruction from the pipeline
  input  wire logic              instr_valid,
  input  wire logic [DW-1:0]     instr_pc,
  input  wire logic [7:0]        opcode,
  input  wire logic [3:0]        cond,
  input  wire logic              fmt_rr,
  input  wire logic [5:0]        src1_tag,
  input  wire logic [5:0]        src2_tag,
  input  wire logic [DW-1:0]     src1_val,
  input  wire logic [DW-1:0]     src2_val,
  input  wire logic              has_src2,
  input  wire logic              is_branch,
  input  wire logic              is_call,
  input  wire logic              tchk_hw_arith,
  input  wire logic              cond_hw_arith,
  input  wire logic              type_fault,
  input  wire logic [5:0]        type_tested,
  input  wire logic [3:0]        ls_trap,
  input  wire logic              instr_no_preempt,
  // Return instructions
  input  wire logic              ret_valid,
  input  wire logic              ret_subvert,
  input  wire logic [DW-1:0]     ret_scr,
  // Interrupt set pulses from memory control logic
  input  wire logic [LEVELS-1:0] imb_irq_set,
  // Entry results
  output logic                   entry_r,
  output logic                   entry_intr_r,
  output logic      [23:0]       vector_r,
  output logic      [WBP_W-1:0]  wbp_r,
  output logic                   ras_push_r,
  output logic      [DW-1:0]     ras_pc_r,
  output logic      [2:0]        slot_we_r,
  output logic      [DW-1:0]     slot0_r,
  output logic      [DW-1:0]     slot1_r,
  output logic      [DW-1:0]     slot2_r,
  // Result substitution and status
  output logic                   subst_valid_r,
  output logic                   subst_call_r,
  output logic      [DW-1:0]     subst_result_r,
  output logic      [DW-1:0]     scr_r
);
  tieu_trap_if tif ();

  logic [3:0]        fpu_cfg_r;
  logic [LEVELS-1:0] int_stat_r;
  logic [DW-1:0]     trap_result_r;
  logic [LEVELS-1:0] irq_cand;
  logic [2:0]        irq_lvl;
  logic              irq_any;
  logic              entry_c;
  logic              trap_c;
  logic              inhibit_c;
  logic [2:0]        cur_lvl;
  logic [LEVELS-1:0] stat_clr;
  logic              wr_scr;
  logic [DW-1:0]     scr_nxt;

  assign tif.opcode        = opcode;
  assign tif.cond          = cond;
  assign tif.fmt_rr        = fmt_rr;
  assign tif.tag1          = src1_tag;
  assign tif.tag2          = src2_tag;
  assign tif.is_branch     = is_branch;
  assign tif.tchk_hw_arith = tchk_hw_arith;
  assign tif.cond_hw_arith = cond_hw_arith;
  assign tif.type_fault    = type_fault;
  assign tif.type_tested   = type_tested;
  assign tif.ls_trap       = ls_trap;
  assign tif.fpu_cfg       = fpu_cfg_r;

  tieu_classify u_cls (
    .t (tif.cls_end)
  );

  assign cur_lvl   = scr_r[`TIEU_SCR_LVL_HI:`TIEU_SCR_LVL_LO];
  assign inhibit_c = instr_no_preempt ||
                     scr_r[`TIEU_SCR_NO_PREEMPT]; // RL9

  // A level is taken only above the level now being serviced
  for (genvar i = 0; i < LEVELS; i++) begin : g_cand
    assign irq_cand[i] = int_stat_r[i] && (i > int'(cur_lvl)) &&
      !((i == int'(`TIEU_LVL_PREEMPT)) && inhibit_c); // RL8 RL9
  end

  always_comb begin
    irq_lvl = 3'h0;
    for (int i = 0; i < LEVELS; i++) begin
      if (irq_cand[i])
        irq_lvl = 3'(i);
    end
  end

  assign irq_any = |irq_cand;
  assign trap_c  = instr_valid && tif.hit;
  assign entry_c = instr_valid && (tif.hit || irq_any); // RL21

  // Register port decode
  assign stat_clr = (reg_wr && reg_addr == `TIEU_REG_INT_STAT) ?
                    reg_wdata[LEVELS-1:0] : '0;
  assign wr_scr   = reg_wr && (reg_addr == `TIEU_REG_SCR);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fpu_cfg_r <= `TIEU_FPU_CFG_RST;
    end else if (reg_wr && reg_addr == `TIEU_REG_FPU_CFG) begin
      fpu_cfg_r <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trap_result_r <= '0;
    end else if (reg_wr && reg_addr == `TIEU_REG_TRAP_RESULT) begin
      trap_result_r <= reg_wdata;
    end
  end

  // Sticky interrupt bits; a new set wins over a clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_stat_r <= '0;
    end else begin
      int_stat_r <= (int_stat_r & ~stat_clr) | imb_irq_set; // RL5
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TIEU_REG_FPU_CFG:     reg_rdata <= DW'(fpu_cfg_r);
        `TIEU_REG_INT_STAT:    reg_rdata <= DW'(int_stat_r);
        `TIEU_REG_SCR:         reg_rdata <= scr_r;
        `TIEU_REG_TRAP_RESULT: reg_rdata <= trap_result_r;
        `TIEU_REG_WBP:         reg_rdata <= DW'(wbp_r);
        `TIEU_REG_VECTOR:      reg_rdata <= DW'(vector_r);
        default:               reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Status control: entry, then return, then subvert use, then write
  always_comb begin
    scr_nxt = scr_r;
    if (entry_c) begin
      if (!trap_c)
        scr_nxt[`TIEU_SCR_LVL_HI:`TIEU_SCR_LVL_LO] = irq_lvl;
    end else if (ret_valid) begin
      scr_nxt = ret_scr; // RL7
      if (ret_subvert)
        scr_nxt[`TIEU_SCR_SUBVERT] = 1'b1; // RL10
    end else if (instr_valid && scr_r[`TIEU_SCR_SUBVERT]) begin
      scr_nxt[`TIEU_SCR_SUBVERT] = 1'b0; // RL10
    end else if (wr_scr) begin
      scr_nxt = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scr_r <= `TIEU_SCR_RST;
    end else begin
      scr_r <= scr_nxt;
    end
  end

  // Retried instruction takes the handler's result
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      subst_valid_r  <= 1'b0;
      subst_call_r   <= 1'b0;
      subst_result_r <= '0;
    end else begin
      subst_valid_r  <= instr_valid && !entry_c &&
                        scr_r[`TIEU_SCR_SUBVERT]; // RL10
      subst_call_r   <= instr_valid && !entry_c && is_call &&
                        scr_r[`TIEU_SCR_SUBVERT]; // RL20
      subst_result_r <= trap_result_r;
    end
  end

  // Window pointer: up on entry, down on return
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wbp_r <= '0;
    end else if (entry_c) begin
      wbp_r <= wbp_r + 1'b1; // RL1
    end else if (ret_valid) begin
      wbp_r <= wbp_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      entry_r      <= 1'b0;
      entry_intr_r <= 1'b0;
      ras_push_r   <= 1'b0;
      ras_pc_r     <= '0;
      vector_r     <= '0;
    end else begin
      entry_r      <= entry_c;
      entry_intr_r <= entry_c && !trap_c;
      ras_push_r   <= entry_c;
      if (entry_c) begin
        ras_pc_r <= instr_pc; // RL1
        if (trap_c)
          vector_r <= {tif.cls, tif.payload, 1'b0}; // RL4
        else
          vector_r <= {TIEU_CLS_INTR, irq_lvl, 18'h00000}; // RL8
      end
    end
  end

  // Handler build window arguments
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot_we_r <= 3'h0;
      slot0_r   <= '0;
      slot1_r   <= '0;
      slot2_r   <= '0;
    end else begin
      slot_we_r <= 3'h0;
      if (entry_c) begin
        slot0_r <= scr_r; // RL2
        slot1_r <= src1_val;
        slot2_r <= src2_val;
        if (trap_c)
          slot_we_r <= {has_src2, 2'b11}; // RL2 RL3
        else
          slot_we_r <= 3'b001; // RL3
      end
    end
  end

  a_wbp_advance: assert property (@(posedge clk) disable iff (!resetn)
    entry_c |=> wbp_r == $past(wbp_r) + 1'b1) // RL1
    else $error("window pointer did not advance on entry");

  a_ras_trap_pc: assert property (@(posedge clk) disable iff (!resetn)
    entry_c |=> ras_push_r && ras_pc_r == $past(instr_pc)) // RL1
    else $error("return stack did not get the trapping pc");

  a_slot0_scr: assert property (@(posedge clk) disable iff (!resetn)
    entry_c |=> slot_we_r[0] && slot0_r == $past(scr_r)) // RL2
    else $error("slot 0 did not receive status control");

  a_intr_one_arg: assert property (@(posedge clk) disable iff (!resetn) // RL3
    entry_c && !trap_c |=> slot_we_r == 3'b001 ##1
    (entry_r || slot_we_r == 3'h0))
    else $error("interrupt entry wrote more than one slot");

  a_vec_opcode: assert property (@(posedge clk) disable iff (!resetn)
    trap_c && tif.cls == TIEU_CLS_ARITH |=>
    vector_r[20:13] == $past(opcode)) // RL4
    else $error("arithmetic vector lacks the opcode");

  a_stat_sticky: assert property (@(posedge clk) disable iff (!resetn)
    !(reg_wr && reg_addr == `TIEU_REG_INT_STAT) |=>
    ($past(int_stat_r) & ~int_stat_r) == '0) // RL5
    else $error("interrupt bit cleared without a write");

  a_preempt_block: assert property (@(posedge clk) disable iff (!resetn)
    entry_c && !trap_c && inhibit_c |->
    irq_lvl != `TIEU_LVL_PREEMPT) // RL9
    else $error("preemption taken while inhibited");

  a_ret_scr_load: assert property (@(posedge clk) disable iff (!resetn)
    ret_valid && !entry_c |=> scr_r[DW-1:2] == $past(ret_scr[DW-1:2])
    && scr_r[`TIEU_SCR_SUBVERT] == $past(ret_scr[1] | ret_subvert))
    // RL7
    else $error("return did not reload status control");

  a_subst_call: assert property (@(posedge clk) disable iff (!resetn)
    instr_valid && is_call && !entry_c && scr_r[`TIEU_SCR_SUBVERT] |=>
    subst_call_r && subst_result_r == $past(trap_result_r)) // RL20
    else $error("subverted call did not load trap result");

  a_stat_clear: assert property (@(posedge clk) disable iff (!resetn) // RL5
    reg_wr && reg_addr == `TIEU_REG_INT_STAT |=>
    (int_stat_r & $past(reg_wdata[LEVELS-1:0] & ~imb_irq_set)) == '0)
    else $error("interrupt bit not cleared by a written one");

  a_subvert_use: assert property (@(posedge clk) disable iff (!resetn) // RL10
    instr_valid && !entry_c && scr_r[`TIEU_SCR_SUBVERT] |=>
    subst_valid_r && !scr_r[`TIEU_SCR_SUBVERT])
    else $error("subverted instruction did not take the result");

  a_trap_first: assert property (@(posedge clk) disable iff (!resetn) // RL21
    trap_c |=>
    !entry_intr_r && vector_r[23:21] == $past(tif.cls))
    else $error("trap entry did not carry the chosen class");

  a_arith_ops: assert property (@(posedge clk) disable iff (!resetn) // RL11
    tif.cls == TIEU_CLS_ARITH |->
    opcode == `TIEU_OP_ADD || opcode == `TIEU_OP_SUB ||
    opcode == `TIEU_OP_MULT)
    else $error("arithmetic trap on a foreign opcode");
endmodule

// ==== verification/tieu_mc_model.sv ====
/*
  Model of the memory control interrupt source: set pulses per level.
  Assumes the core clock; pulses change just after a rising edge.
*/
`timescale 1ns/100ps
module tieu_mc_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Set pulses toward the unit
  output logic      [7:0] irq_set
);
  initial irq_set = 8'h00;

  // One-cycle pulse; level 1 asks for preemption
  task automatic raise(input logic [7:0] lv);
    @(posedge clk);
    irq_set <= resetn ? lv : 8'h00;
    @(posedge clk);
    irq_set <= 8'h00;
  endtask
endmodule

// ==== verification/tb_top.sv ====
/*
  Self-checking bench of the trap and interrupt entry unit.
  Assumes the unit's default parameters and a 50 MHz core clock.
*/
`timescale 1ns/100ps
`include "tieu_consts.svh"
module tb_top;
  localparam logic [6:0] fl_s2 = 7'h01, fl_hw = 7'h02, fl_br = 7'h04;
  localparam logic [6:0] fl_tf = 7'h08, fl_rr = 7'h10, fl_np = 7'h20;
  localparam logic [6:0] fl_call = 7'h40;
  logic        clk, resetn, reg_wr, reg_rd, instr_valid, fmt_rr, has_src2;
  logic        is_branch, is_call, tchk_hw_arith, cond_hw_arith;
  logic        type_fault, instr_no_preempt, ret_valid, ret_subvert;
  logic        entry_r, entry_intr_r, ras_push_r, subst_valid_r;
  logic        subst_call_r;
  logic [7:0]  reg_addr, opcode, imb_irq_set;
  logic [3:0]  cond, ls_trap, wbp_r, wbp_exp;
  logic [5:0]  src1_tag, src2_tag, type_tested;
  logic [2:0]  slot_we_r;
  logic [23:0] vector_r;
  logic [31:0] reg_wdata, reg_rdata, instr_pc, src1_val, src2_val, ret_scr;
  logic [31:0] ras_pc_r, slot0_r, slot1_r, slot2_r, subst_result_r, scr_r;
  logic [31:0] pc, scr_exp;
  int          error_cnt, checks;

  tieu_unit u_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .instr_valid, .instr_pc, .opcode, .cond, .fmt_rr,
    .src1_tag, .src2_tag, .src1_val, .src2_val, .has_src2, .is_branch,
    .is_call, .tchk_hw_arith, .cond_hw_arith, .type_fault, .type_tested,
    .ls_trap, .instr_no_preempt, .ret_valid, .ret_subvert, .ret_scr,
    .imb_irq_set, .entry_r, .entry_intr_r, .vector_r, .wbp_r, .ras_push_r,
    .ras_pc_r, .slot_we_r, .slot0_r, .slot1_r, .slot2_r, .subst_valid_r,
    .subst_call_r, .subst_result_r, .scr_r);
  tieu_mc_model u_mc (.clk(clk), .resetn(resetn), .irq_set(imb_irq_set));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("rdata", reg_rdata, exp);
  endtask

  // One instruction; a zero vector means no entry is expected
  task automatic run(input logic [7:0] op, input logic [5:0] t1, t2,
                     input logic [3:0] ls, input logic [6:0] f,
                     input logic [23:0] ev);
    logic intr;
    intr = (ev[23:21] == 3'd5);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_pc <= pc;
    src1_val <= pc ^ 32'h5a5a_0000;
    src2_val <= ~pc;
    opcode <= op;
    src1_tag <= t1;
    src2_tag <= t2;
    ls_trap <= ls;
    has_src2 <= f[0];
    tchk_hw_arith <= f[1];
    cond_hw_arith <= f[1];
    is_branch <= f[2];
    type_fault <= f[3];
    fmt_rr <= f[4];
    instr_no_preempt <= f[5];
    is_call <= f[6];
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    check("entry", entry_r, ev != 24'h0);
    if (ev != 24'h0) begin
      wbp_exp = wbp_exp + 4'h1;
      check("vector", vector_r, ev);
      check("intr", entry_intr_r, intr);
      check("push", ras_push_r, 1'b1);
      check("ras_pc", ras_pc_r, pc);
      check("wbp", wbp_r, wbp_exp);
      check("slot_we", slot_we_r, intr ? 3'b001 : {f[0], 2'b11});
      check("slot0", slot0_r, scr_exp);
      if (!intr) check("slot1", slot1_r, pc ^ 32'h5a5a_0000);
      if (f[0] && !intr) check("slot2", slot2_r, ~pc);
      if (intr) scr_exp[6:4] = ev[20:18];
    end
    pc = pc + 32'h4;
  endtask

  task automatic ret(input logic sv, input logic [31:0] rs);
    @(posedge clk);
    ret_valid <= 1'b1;
    ret_subvert <= sv;
    ret_scr <= rs;
    @(posedge clk);
    ret_valid <= 1'b0;
    #1;
    wbp_exp = wbp_exp - 4'h1;
    scr_exp = rs | {30'h0, sv, 1'b0};
    check("scr", scr_r, scr_exp);
    check("wbp", wbp_r, wbp_exp);
  endtask

  task automatic t_reset();
    rd(`TIEU_REG_SCR, 32'h0);
    rd(`TIEU_REG_INT_STAT, 32'h0);
    wr(`TIEU_REG_VECTOR, 32'hffff_ffff);
    rd(`TIEU_REG_VECTOR, 32'h0);
    rd(8'h40, 32'h0);
  endtask

  task automatic t_ls();
    for (int k = 0; k < 4; k++)
      run(8'h40, 6'h20, 6'h21, 4'h1 << k, 7'h0,
          {3'd1, 8'h40, k[1:0], 10'h0, 1'b0});
    run(8'h41, 6'h20, 6'h21, 4'h9, fl_tf,
        {3'd1, 8'h41, 2'd0, 10'h0, 1'b0});
  endtask

  task automatic t_arith();
    run(`TIEU_OP_ADD, 6'h09, 6'h0a, 4'h0, fl_s2,
        {3'd2, `TIEU_OP_ADD, 6'h09, 6'h0a, 1'b0});
    run(`TIEU_OP_SUB, 6'h08, 6'h08, 4'h0, fl_s2, 24'h0);
    run(`TIEU_OP_ADD, 6'h09, 6'h0a, 4'h0, fl_s2 | fl_hw, 24'h0);
    run(8'h20, 6'h09, 6'h0a, 4'h0, fl_s2, 24'h0);
    wr(`TIEU_REG_FPU_CFG, 32'h1);
    run(`TIEU_OP_ADD, 6'h0a, 6'h0a, 4'h0, fl_s2, 24'h0);
    wr(`TIEU_REG_FPU_CFG, 32'h0);
    run(`TIEU_OP_SUB, 6'h0a, 6'h0a, 4'h0, fl_s2,
        {3'd2, `TIEU_OP_SUB, 6'h0a, 6'h0a, 1'b0});
    run(`TIEU_OP_MULT, 6'h08, 6'h08, 4'h0, fl_s2,
        {3'd2, `TIEU_OP_MULT, 6'h08, 6'h08, 1'b0});
    wr(`TIEU_REG_FPU_CFG, 32'h2);
    run(`TIEU_OP_MULT, 6'h08, 6'h08, 4'h0, fl_s2, 24'h0);
    run(`TIEU_OP_MULT, 6'h0a, 6'h0a, 4'h0, fl_s2,
        {3'd2, `TIEU_OP_MULT, 6'h0a, 6'h0a, 1'b0});
    wr(`TIEU_REG_FPU_CFG, 32'h4);
    rd(`TIEU_REG_FPU_CFG, 32'h4);
    run(`TIEU_OP_MULT, 6'h0a, 6'h0a, 4'h0, fl_s2, 24'h0);
  endtask

  task automatic t_branch();
    wr(`TIEU_REG_FPU_CFG, 32'h0);
    run(8'h35, 6'h09, 6'h0b, 4'h0, fl_s2 | fl_br,
        {3'd3, 4'h5, 4'h5, 6'h09, 6'h0b, 1'b0});
    run(8'h35, 6'h09, 6'h0b, 4'h0, fl_s2 | fl_br | fl_hw, 24'h0);
    run(8'h35, 6'h08, 6'h08, 4'h0, fl_s2 | fl_br, 24'h0);
    run(8'h35, 6'h0a, 6'h0a, 4'h0, fl_s2 | fl_br,
        {3'd3, 4'h5, 4'h5, 6'h0a, 6'h0a, 1'b0});
    wr(`TIEU_REG_FPU_CFG, 32'h8);
    run(8'h35, 6'h0a, 6'h0a, 4'h0, fl_s2 | fl_br, 24'h0);
  endtask

  task automatic t_type();
    run(8'h50, 6'h20, 6'h21, 4'h0, fl_s2 | fl_tf | fl_rr,
        {3'd4, 8'h50, 6'h15, 1'b1, 5'h0, 1'b0});
    run(8'h50, 6'h20, 6'h21, 4'h0, fl_tf,
        {3'd4, 8'h50, 6'h15, 1'b0, 5'h0, 1'b0});
    rd(`TIEU_REG_VECTOR, {8'h0, 3'd4, 8'h50, 6'h15, 7'h0});
    rd(`TIEU_REG_WBP, {28'h0, wbp_exp});
  endtask

  task automatic t_intr();
    u_mc.raise(8'h08);
    rd(`TIEU_REG_INT_STAT, 32'h08);
    rd(`TIEU_REG_INT_STAT, 32'h08);
    run(8'h20, 6'h0, 6'h0, 4'h0, fl_s2,
        {3'd5, 3'd3, 17'h0, 1'b0});
    rd(`TIEU_REG_SCR, scr_exp);
    wr(`TIEU_REG_INT_STAT, 32'h0);
    rd(`TIEU_REG_INT_STAT, 32'h08);
    wr(`TIEU_REG_INT_STAT, 32'h08);
    rd(`TIEU_REG_INT_STAT, 32'h0);
    ret(1'b0, 32'h0);
  endtask

  task automatic t_preempt();
    wr(`TIEU_REG_SCR, 32'h1);
    scr_exp = 32'h1;
    u_mc.raise(8'h02);
    run(8'h20, 6'h0, 6'h0, 4'h0, 7'h0, 24'h0);
    wr(`TIEU_REG_SCR, 32'h0);
    scr_exp = 32'h0;
    run(8'h20, 6'h0, 6'h0, 4'h0, fl_np, 24'h0);
    u_mc.raise(8'h04);
    run(8'h20, 6'h0, 6'h0, 4'h0, fl_np, {3'd5, 3'd2, 17'h0, 1'b0});
    wr(`TIEU_REG_INT_STAT, 32'h04);
    ret(1'b0, 32'h0);
    run(8'h20, 6'h0, 6'h0, 4'h0, 7'h0, {3'd5, 3'd1, 17'h0, 1'b0});
    wr(`TIEU_REG_INT_STAT, 32'h02);
    rd(`TIEU_REG_INT_STAT, 32'h0);
    ret(1'b0, 32'h0);
  endtask

  task automatic t_subvert();
    wr(`TIEU_REG_TRAP_RESULT, 32'h0000_1234);
    ret(1'b1, 32'h0);
    run(8'h60, 6'h0, 6'h0, 4'h0, fl_call, 24'h0);
    check("subst", subst_valid_r, 1'b1);
    check("subst_call", subst_call_r, 1'b1);
    check("subst_result", subst_result_r, 32'h0000_1234);
    check("scr", scr_r, 32'h0);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    {resetn, reg_wr, reg_rd, instr_valid, fmt_rr, has_src2} = 6'h0;
    {is_branch, is_call, tchk_hw_arith, cond_hw_arith} = 4'h0;
    {type_fault, instr_no_preempt, ret_valid, ret_subvert} = 4'h0;
    {reg_addr, reg_wdata, instr_pc, src1_val, src2_val} = 136'h0;
    {opcode, cond, ls_trap, src1_tag, src2_tag, ret_scr} = 60'h0;
    cond = 4'h5;
    type_tested = 6'h15;
    {pc, scr_exp, wbp_exp} = {32'h100, 32'h0, 4'h0};
    error_cnt = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_ls();
    t_arith();
    t_branch();
    t_type();
    t_intr();
    t_preempt();
    t_subvert();
    print_verdict();
  end
endmodule
